// *** hdl/mrr_pkg.sv ***
/*
 Constants, types and helpers shared by the register responder and its
 testbench. Assumes one 20 MHz clock and a byte-wide request stream.
*/
// Functional notes
// - Every register carries exactly sixteen bits of data.
// - Wider values span consecutive registers, high word first.
// - Floats are single precision: one sign, eight exponent, 23 mantissa bits.
// - 16-bit types take one register; 32-bit ints and floats take two.
// - A malformed request gets an exception reply, not a normal one.
// - Unimplemented function code answers exception 01.
// - Any write while not in remote operation answers exception 01.
// - Unimplemented register address answers exception 02.
// - Start and length splitting a two-register value answers exception 02.
// - Write to a read-only register answers exception 02.
// - Written value outside its permitted range is refused with exception 03.
// - Function 03 returns the contents of several holding registers.
// - Function 06 updates one holding register.
// - Function 16 writes consecutive registers; client uses it for wide values.
// - Function 23 writes then reads registers in one transaction.
package mrr_pkg;
   localparam int WORD_BITS = 16;
   localparam int FLT_SIGN_BITS = 1;
   localparam int FLT_EXP_BITS = 8;
   localparam int FLT_MAN_BITS = 23;
   localparam int REGS_SHORT = 1;
   localparam int REGS_WIDE = 2;

   localparam logic [7:0] FC_READ = 8'h03;
   localparam logic [7:0] FC_INPUT = 8'h04;
   localparam logic [7:0] FC_WRITE1 = 8'h06;
   localparam logic [7:0] FC_WRITEN = 8'h10;
   localparam logic [7:0] FC_RDWR = 8'h17;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_FUNC = 8'h01;
   localparam logic [7:0] EXC_ADDR = 8'h02;
   localparam logic [7:0] EXC_VALUE = 8'h03;

   localparam logic [3:0] HDR_LEN_READ = 4'h4;
   localparam logic [3:0] HDR_LEN_WRITE1 = 4'h2;
   localparam logic [3:0] HDR_LEN_WRITEN = 4'h5;
   localparam logic [3:0] HDR_LEN_RDWR = 4'h9;
   localparam logic [3:0] RSP_LEN_READ = 4'h2;
   localparam logic [3:0] RSP_LEN_WRITE = 4'h5;

   localparam logic [15:0] QTY_RD_MAX = 16'h007D;
   localparam logic [15:0] QTY_WN_MAX = 16'h007B;
   localparam logic [15:0] QTY_RW_MAX = 16'h0079;

   localparam logic [15:0] ADDR_RUN = 16'h0000;
   localparam logic [15:0] ADDR_ACT_SRC = 16'h0001;
   localparam logic [15:0] ADDR_ACT_VAL = 16'h0004;
   localparam logic [15:0] RUN_MAX = 16'h0001;
   localparam logic [15:0] ACT_SRC_MAX = 16'h0002;
   localparam logic [15:0] ACT_VAL_MIN = 16'hFF9C;
   localparam logic [15:0] ACT_VAL_MAX = 16'h0064;
   localparam logic [15:0] SETPOINT_ADDR = 16'h0002;

   localparam logic [15:0] FAULT_COMM = 16'hFA23;
   localparam logic [15:0] FAULT_NONE = 16'h0000;
   localparam int CLK_HZ = 20_000_000;
   localparam int WD_TICK_MS = 1;
   localparam int WD_TICK_CYCLES = CLK_HZ / 1000 * WD_TICK_MS;

   typedef enum logic [3:0] {
      S_FC, S_HDR, S_QTY, S_CHECK, S_DATA, S_DRAIN,
      S_RSP, S_FETCH, S_HI, S_LO, S_EXC
   } mrr_state_t;

   function automatic logic [3:0] mrr_hdr_len(input logic [7:0] fc);
      case (fc)
         FC_READ, FC_INPUT: mrr_hdr_len = HDR_LEN_READ;
         FC_WRITE1: mrr_hdr_len = HDR_LEN_WRITE1;
         FC_WRITEN: mrr_hdr_len = HDR_LEN_WRITEN;
         FC_RDWR: mrr_hdr_len = HDR_LEN_RDWR;
         default: mrr_hdr_len = 4'h0;
      endcase
   endfunction

   // Only integer registers have a checked range; floats pass unchanged
   function automatic logic mrr_value_ok(input logic [15:0] a,
                                         input logic [15:0] v);
      case (a)
         ADDR_RUN: mrr_value_ok = (v <= RUN_MAX);
         ADDR_ACT_SRC: mrr_value_ok = (v <= ACT_SRC_MAX);
         ADDR_ACT_VAL: mrr_value_ok = ($signed(v) >= $signed(ACT_VAL_MIN)) &&
                                      ($signed(v) <= $signed(ACT_VAL_MAX));
         default: mrr_value_ok = 1'b1;
      endcase
   endfunction
endpackage

// *** hdl/mrr_regmem.sv ***
/*
 Holding-register store: one write port, one read port with registered
 read data. Assumes writes are already validated by the responder.
*/
`timescale 1ns/1ps
module mrr_regmem #(
   parameter int WORDS = 128,
   parameter int AW = 7
) (
   input wire logic core_clk, // Clock
   input wire logic srst, // Sync reset of the read register
   input wire logic we, // Write strobe
   input wire logic [AW-1:0] waddr, // Write index
   input wire logic [15:0] wdata, // Write word
   input wire logic [AW-1:0] raddr, // Read index
   output logic [15:0] rdata // Read word, one cycle after raddr
);
   logic [15:0] mem [WORDS];
   logic [15:0] rdata_d;

   always_comb begin
      rdata_d = mem[raddr];
   end

   always_ff @(posedge core_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      if (srst) begin
         rdata <= 16'h0000;
      end else begin
         rdata <= rdata_d;
      end
   end
endmodule // mrr_regmem

// *** hdl/mrr_responder.sv ***
/*
 Register-access responder: parses one request PDU from a byte stream,
 validates it, commits writes and streams back the reply; also keeps the
 setpoint watchdog. Assumes framing (MBAP header) is stripped outside.
*/
`timescale 1ns/1ps
module mrr_responder
   import mrr_pkg::*;
#(
   parameter int REG_WORDS = 128,
   parameter logic [REG_WORDS-1:0] IMPL_MASK = '1,
   parameter logic [REG_WORDS-1:0] RO_MASK = '0,
   parameter logic [REG_WORDS-1:0] PAIR_MASK = REG_WORDS'(8'h04),
   parameter int WD_TICK = mrr_pkg::WD_TICK_CYCLES
) (
   input wire logic core_clk, // 20 MHz clock
   input wire logic srst, // Sync reset, active high
   input wire logic req_valid, // Request byte valid
   input wire logic [7:0] req_data, // Request byte
   input wire logic req_last, // Last byte of the request PDU
   output logic req_ready, // Request byte accepted
   output logic rsp_valid, // Reply byte valid
   output logic [7:0] rsp_data, // Reply byte
   output logic rsp_last, // Last byte of the reply PDU
   input wire logic rsp_ready, // Reply byte taken
   input wire logic remote_mode, // Writes allowed
   input wire logic wd_enable, // Watchdog on
   input wire logic [15:0] wd_timeout_ms, // Watchdog timeout
   output logic wr_pulse, // One register committed
   output logic [15:0] wr_addr, // Committed address
   output logic [15:0] wr_data, // Committed word
   output logic comm_fault, // Watchdog fault, sticky
   output logic [15:0] fault_code // Fault number while faulted
);
   import mrr_pkg::*;
   localparam int AW = $clog2(REG_WORDS);

   mrr_state_t st_q, st_d;
   logic [7:0] fc_q, fc_d, err_q, err_d, hi_q, hi_d;
   logic [71:0] h_q, h_d;
   logic [3:0] cnt_q, cnt_d;
   logic [15:0] idx_q, idx_d, wv_q, wv_d;
   logic ck_wr_q, ck_wr_d, done_q, done_d, rdy_q, rdy_d;
   logic rv_q, rv_d, rl_q, rl_d, wp_q, wp_d;
   logic [7:0] rd_q, rd_d;
   logic [15:0] wa_q, wa_d, wdq_q, wdq_d;
   logic [15:0] rd_start, rd_qty, wr_start, wr_qty, sp_start, sp_qty;
   logic [7:0] bcnt, hb, e;
   logic has_read, is_write, take, can_push, oob, span_bad, last_sp;
   logic [16:0] cur;
   logic [AW-1:0] cur_ix;
   logic [15:0] wa_full, wvalue, rd_addr;
   logic wok, mem_we;
   logic [15:0] mem_rdata;

   assign take = req_valid && rdy_q;
   assign can_push = !rv_q || rsp_ready;
   assign has_read = (fc_q == FC_READ) || (fc_q == FC_RDWR);
   assign is_write = (fc_q == FC_WRITE1) || (fc_q == FC_WRITEN) ||
                     (fc_q == FC_RDWR);
   assign sp_start = ck_wr_q ? wr_start : rd_start;
   assign sp_qty = ck_wr_q ? wr_qty : rd_qty;
   assign cur = {1'b0, sp_start} + {1'b0, idx_q};
   assign cur_ix = cur[AW-1:0];
   assign oob = cur >= 17'(REG_WORDS);
   assign last_sp = idx_q == sp_qty - 16'h0001;
   // A span may neither begin on the low half nor end on the high half
   assign span_bad = oob || !IMPL_MASK[cur_ix] ||
                     (ck_wr_q && RO_MASK[cur_ix]) ||
                     ((idx_q == 16'h0000) && (cur != 17'h00000) &&
                      PAIR_MASK[cur_ix - 1'b1]) ||
                     (last_sp && PAIR_MASK[cur_ix]);
   assign wa_full = wr_start + idx_q;
   assign rd_addr = rd_start + idx_q;
   assign wvalue = {hi_q, req_data};
   assign wok = mrr_value_ok(wa_full, wvalue);

   // Request fields, big-endian as they arrive
   always_comb begin
      rd_start = 16'h0000;
      rd_qty = 16'h0000;
      wr_start = 16'h0000;
      wr_qty = 16'h0000;
      bcnt = 8'h00;
      case (fc_q)
         FC_READ, FC_INPUT: begin
            rd_start = h_q[31:16];
            rd_qty = h_q[15:0];
         end
         FC_WRITE1: begin
            wr_start = h_q[15:0];
            wr_qty = 16'h0001;
         end
         FC_WRITEN: begin
            wr_start = h_q[39:24];
            wr_qty = h_q[23:8];
            bcnt = h_q[7:0];
         end
         FC_RDWR: begin
            rd_start = h_q[71:56];
            rd_qty = h_q[55:40];
            wr_start = h_q[39:24];
            wr_qty = h_q[23:8];
            bcnt = h_q[7:0];
         end
         default: ;
      endcase
   end

   always_comb begin
      st_d = st_q;
      fc_d = fc_q;
      err_d = err_q;
      hi_d = hi_q;
      h_d = h_q;
      cnt_d = cnt_q;
      idx_d = idx_q;
      wv_d = wv_q;
      ck_wr_d = ck_wr_q;
      done_d = done_q;
      rv_d = rv_q && !rsp_ready;
      rd_d = rd_q;
      rl_d = rl_q;
      wp_d = 1'b0;
      wa_d = wa_q;
      wdq_d = wdq_q;
      mem_we = 1'b0;
      e = EXC_NONE;
      hb = fc_q;
      case (st_q)
         S_FC: if (take) begin
            fc_d = req_data;
            h_d = 72'h0;
            cnt_d = 4'h0;
            err_d = EXC_NONE;
            done_d = req_last;
            if (mrr_hdr_len(req_data) == 4'h0) begin
               err_d = EXC_FUNC;
               st_d = req_last ? S_EXC : S_DRAIN;
            end else if (req_last) begin
               err_d = EXC_VALUE;
               st_d = S_EXC;
            end else begin
               st_d = S_HDR;
            end
         end
         S_HDR: if (take) begin
            h_d = {h_q[63:0], req_data};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == mrr_hdr_len(fc_q) - 4'h1) begin
               done_d = req_last;
               st_d = S_QTY;
            end else if (req_last) begin
               err_d = EXC_VALUE;
               done_d = 1'b1;
               st_d = S_EXC;
            end
         end
         S_QTY: begin
            if (is_write && !remote_mode) e = EXC_FUNC;
            else if (fc_q == FC_INPUT) e = EXC_ADDR;
            else if (has_read && (rd_qty == 16'h0000 || rd_qty > QTY_RD_MAX))
               e = EXC_VALUE;
            else if (fc_q == FC_WRITEN &&
                     (wr_qty == 16'h0000 || wr_qty > QTY_WN_MAX))
               e = EXC_VALUE;
            else if (fc_q == FC_RDWR &&
                     (wr_qty == 16'h0000 || wr_qty > QTY_RW_MAX))
               e = EXC_VALUE;
            else if (fc_q != FC_WRITE1 && is_write &&
                     {8'h00, bcnt} != {wr_qty[14:0], 1'b0})
               e = EXC_VALUE;
            else if (is_write == done_q) e = EXC_VALUE;
            err_d = e;
            idx_d = 16'h0000;
            ck_wr_d = !has_read;
            if (e != EXC_NONE) st_d = done_q ? S_EXC : S_DRAIN;
            else st_d = S_CHECK;
         end
         S_CHECK: begin
            idx_d = idx_q + 16'h0001;
            if (span_bad) begin
               err_d = EXC_ADDR;
               st_d = done_q ? S_EXC : S_DRAIN;
            end else if (last_sp && !ck_wr_q && is_write) begin
               ck_wr_d = 1'b1;
               idx_d = 16'h0000;
            end else if (last_sp) begin
               idx_d = 16'h0000;
               cnt_d = 4'h0;
               st_d = is_write ? S_DATA : S_RSP;
            end
         end
         S_DATA: if (take) begin
            cnt_d[0] = !cnt_q[0];
            if (!cnt_q[0]) begin
               hi_d = req_data;
               if (req_last) begin
                  if (err_q == EXC_NONE) err_d = EXC_VALUE;
                  st_d = S_EXC;
               end
            end else begin
               // Words commit as they arrive; a refused word stops the rest
               wv_d = wvalue;
               idx_d = idx_q + 16'h0001;
               if (err_q == EXC_NONE && wok) begin
                  mem_we = 1'b1;
                  wp_d = 1'b1;
                  wa_d = wa_full;
                  wdq_d = wvalue;
               end else if (err_q == EXC_NONE) begin
                  err_d = EXC_VALUE;
               end
               if (idx_q == wr_qty - 16'h0001 && req_last) begin
                  idx_d = 16'h0000;
                  cnt_d = 4'h0;
                  st_d = (err_d == EXC_NONE) ? S_RSP : S_EXC;
               end else if (idx_q == wr_qty - 16'h0001 || req_last) begin
                  if (err_d == EXC_NONE) err_d = EXC_VALUE;
                  st_d = req_last ? S_EXC : S_DRAIN;
               end
            end
         end
         S_DRAIN: if (take && req_last) begin
            cnt_d = 4'h0;
            st_d = S_EXC;
         end
         S_EXC: if (can_push) begin
            rv_d = 1'b1;
            rd_d = (cnt_q == 4'h0) ? (fc_q | EXC_FLAG) : err_q;
            rl_d = cnt_q != 4'h0;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q != 4'h0) st_d = S_FC;
         end
         S_RSP: begin
            case (cnt_q)
               4'h0: hb = fc_q;
               4'h1: hb = has_read ? {rd_qty[6:0], 1'b0} : wr_start[15:8];
               4'h2: hb = wr_start[7:0];
               4'h3: hb = (fc_q == FC_WRITE1) ? wv_q[15:8] : wr_qty[15:8];
               default: hb = (fc_q == FC_WRITE1) ? wv_q[7:0] : wr_qty[7:0];
            endcase
            if (can_push) begin
               rv_d = 1'b1;
               rd_d = hb;
               cnt_d = cnt_q + 4'h1;
               rl_d = 1'b0;
               if (cnt_q == (has_read ? RSP_LEN_READ : RSP_LEN_WRITE) - 4'h1)
               begin
                  rl_d = !has_read;
                  st_d = has_read ? S_FETCH : S_FC;
               end
            end
         end
         S_FETCH: st_d = S_HI;
         S_HI: if (can_push) begin
            rv_d = 1'b1;
            rd_d = mem_rdata[15:8];
            rl_d = 1'b0;
            st_d = S_LO;
         end
         S_LO: if (can_push) begin
            rv_d = 1'b1;
            rd_d = mem_rdata[7:0];
            rl_d = idx_q == rd_qty - 16'h0001;
            idx_d = idx_q + 16'h0001;
            st_d = (idx_q == rd_qty - 16'h0001) ? S_FC : S_FETCH;
         end
         default: st_d = S_FC;
      endcase
      // Header and span walks leave the counter mid-way; restart it so
      // every exception reply opens with its echoed function code
      if (st_d == S_EXC && st_q != S_EXC) cnt_d = 4'h0;
      rdy_d = (st_d == S_FC) || (st_d == S_HDR) || (st_d == S_DATA) ||
              (st_d == S_DRAIN);
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_q <= S_FC;
         fc_q <= 8'h00;
         err_q <= EXC_NONE;
         hi_q <= 8'h00;
         h_q <= 72'h0;
         cnt_q <= 4'h0;
         idx_q <= 16'h0000;
         wv_q <= 16'h0000;
         ck_wr_q <= 1'b0;
         done_q <= 1'b0;
         rdy_q <= 1'b0;
         rv_q <= 1'b0;
         rd_q <= 8'h00;
         rl_q <= 1'b0;
         wp_q <= 1'b0;
         wa_q <= 16'h0000;
         wdq_q <= 16'h0000;
      end else begin
         st_q <= st_d;
         fc_q <= fc_d;
         err_q <= err_d;
         hi_q <= hi_d;
         h_q <= h_d;
         cnt_q <= cnt_d;
         idx_q <= idx_d;
         wv_q <= wv_d;
         ck_wr_q <= ck_wr_d;
         done_q <= done_d;
         rdy_q <= rdy_d;
         rv_q <= rv_d;
         rd_q <= rd_d;
         rl_q <= rl_d;
         wp_q <= wp_d;
         wa_q <= wa_d;
         wdq_q <= wdq_d;
      end
   end

   mrr_regmem #(.WORDS(REG_WORDS), .AW(AW)) u_mem (
      .core_clk(core_clk),
      .srst(srst),
      .we(mem_we),
      .waddr(wa_full[AW-1:0]),
      .wdata(wvalue),
      .raddr(rd_addr[AW-1:0]),
      .rdata(mem_rdata)
   );

   // Setpoint watchdog; either half of the float setpoint re-arms it
   logic [23:0] pre_q, pre_d;
   logic [15:0] ms_q, ms_d, fc_code_d;
   logic flt_q, flt_d, tick, sp_wr, expire;

   assign tick = pre_q == 24'(WD_TICK - 1);
   assign sp_wr = mem_we && (wa_full == SETPOINT_ADDR ||
                             wa_full == SETPOINT_ADDR + 16'h0001);
   assign expire = wd_enable && tick && !sp_wr &&
                   ({1'b0, ms_q} + 17'h00001 >= {1'b0, wd_timeout_ms});

   always_comb begin
      pre_d = tick ? 24'h000000 : pre_q + 24'h000001;
      ms_d = (tick && ms_q != 16'hFFFF) ? ms_q + 16'h0001 : ms_q;
      if (sp_wr || !wd_enable) begin
         pre_d = 24'h000000;
         ms_d = 16'h0000;
      end
      flt_d = expire || (flt_q && !sp_wr);
      fc_code_d = flt_d ? FAULT_COMM : FAULT_NONE;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         pre_q <= 24'h000000;
         ms_q <= 16'h0000;
         flt_q <= 1'b0;
         fault_code <= FAULT_NONE;
      end else begin
         pre_q <= pre_d;
         ms_q <= ms_d;
         flt_q <= flt_d;
         fault_code <= fc_code_d;
      end
   end

   assign req_ready = rdy_q;
   assign rsp_valid = rv_q;
   assign rsp_data = rd_q;
   assign rsp_last = rl_q;
   assign wr_pulse = wp_q;
   assign wr_addr = wa_q;
   assign wr_data = wdq_q;
   assign comm_fault = flt_q;

   default clocking cb_core @(posedge core_clk); endclocking
   default disable iff (srst);

   sequence seq_exc_head;
      st_q == S_EXC && cnt_q == 4'h0 && can_push;
   endsequence
   sequence seq_exc_tail;
      rv_q && rsp_data == (fc_q | EXC_FLAG) && !rl_q;
   endsequence

   chk_unsup_fc: assert property (
      st_q == S_FC && take && mrr_hdr_len(req_data) == 4'h0
      |=> err_q == EXC_FUNC) else $error("unsupported code not flagged 01");
   chk_remote_write: assert property (
      st_q == S_QTY && is_write && !remote_mode
      |=> err_q == EXC_FUNC) else $error("local-mode write not flagged 01");
   chk_span_addr: assert property (
      st_q == S_CHECK && span_bad |=> err_q == EXC_ADDR)
      else $error("bad address span not flagged 02");
   chk_range_value: assert property (
      st_q == S_DATA && take && cnt_q[0] && !wok && err_q == EXC_NONE
      |-> !mem_we ##1 err_q == EXC_VALUE && !wp_q)
      else $error("out-of-range word accepted");
   chk_exc_reply: assert property (
      seq_exc_head |=> seq_exc_tail ##[1:300] (rv_q && rl_q &&
      rsp_data == err_q)) else $error("exception reply malformed");
   chk_write_commit: assert property (
      mem_we |-> st_q == S_DATA && err_q == EXC_NONE ##1
      wp_q && wr_data == $past(wvalue)) else $error("write commit wrong");
   // The low byte may go out in the very cycle after the high byte
   chk_read_word: assert property (
      st_q == S_HI && can_push |=> rsp_data == $past(mem_rdata[15:8])
      ##[0:300] (st_q == S_LO && can_push)) else $error("read word order");
   chk_wd_fault: assert property (
      expire |=> (flt_q && fault_code == FAULT_COMM) [*2]
      or (flt_q && fault_code == FAULT_COMM ##1 !flt_q))
      else $error("watchdog fault not raised");
   chk_wd_rearm: assert property (
      sp_wr |=> ms_q == 16'h0000 && !flt_q) else $error("setpoint no rearm");
endmodule // mrr_responder

// *** test/mrr_client_model.sv ***
/*
 Remote client model: sends request PDUs byte by byte and collects the
 reply, promptly or with a stalling rsp_ready. Assumes one clock shared
 with the responder and registered outputs on the responder side.
*/
`timescale 1ns/1ps
module mrr_client_model (
   input wire logic core_clk, // Clock
   input wire logic req_ready, // Request byte taken
   output logic req_valid, // Request byte valid
   output logic [7:0] req_data, // Request byte
   output logic req_last, // Final request byte
   input wire logic rsp_valid, // Reply byte valid
   input wire logic [7:0] rsp_data, // Reply byte
   input wire logic rsp_last, // Final reply byte
   output logic rsp_ready // Reply byte consumed
);
   initial begin
      req_valid = 1'b0;
      req_data = 8'h00;
      req_last = 1'b0;
      rsp_ready = 1'b0;
   end
   // Fields go out hi byte first, wide values high word first
   task automatic send(input logic [7:0] q[$]);
      int i;
      @(posedge core_clk);
      for (i = 0; i < q.size(); i++) begin
         req_valid <= 1'b1;
         req_data <= q[i];
         req_last <= (i == q.size() - 1);
         do @(posedge core_clk); while (req_ready !== 1'b1);
      end
      req_valid <= 1'b0;
      req_last <= 1'b0;
      // A released line must not keep showing the last byte
      req_data <= ~q[q.size() - 1];
   endtask
   task automatic recv(output logic [7:0] q[$], input bit slow);
      int n;
      bit done;
      q = {};
      done = 1'b0;
      for (n = 0; n < 300 && !done; n++) begin
         @(posedge core_clk);
         if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
            q.push_back(rsp_data);
            done = (rsp_last === 1'b1);
         end
         rsp_ready <= done ? 1'b0 : (slow ? ~rsp_ready : 1'b1);
      end
   endtask
endmodule // mrr_client_model

// *** test/tb_modbus_register_responder.sv ***
/*
 Self-checking bench of the register responder with a client model.
 Assumes the default register masks except register 5 made read-only.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
 mismatches++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_modbus_register_responder;
   import mrr_pkg::*;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic req_valid, req_last, req_ready, rsp_valid, rsp_last, rsp_ready;
   logic [7:0] req_data, rsp_data;
   logic remote_mode = 1'b1;
   logic wd_enable = 1'b0;
   logic [15:0] wd_timeout_ms = 16'h0005;
   logic wr_pulse, comm_fault;
   logic [15:0] wr_addr, wr_data, fault_code;
   int mismatches = 0;
   int n_tests = 0;
   int n_wr = 0;
   int cyc = 0;
   always #25 core_clk = ~core_clk;
   mrr_client_model client (.core_clk(core_clk), .req_ready(req_ready),
      .req_valid(req_valid), .req_data(req_data), .req_last(req_last),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
      .rsp_ready(rsp_ready));
   mrr_responder #(.RO_MASK(128'h20), .WD_TICK(4)) DUT (
      .core_clk(core_clk), .srst(srst), .req_valid(req_valid),
      .req_data(req_data), .req_last(req_last), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
      .rsp_ready(rsp_ready), .remote_mode(remote_mode),
      .wd_enable(wd_enable), .wd_timeout_ms(wd_timeout_ms),
      .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data),
      .comm_fault(comm_fault), .fault_code(fault_code));
   always @(posedge core_clk) begin
      if (wr_pulse === 1'b1) n_wr <= n_wr + 1;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Ceiling well above the few hundred cycles the tests need
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         close_out();
      end
   end
   task automatic xact(input logic [7:0] rq[$], input logic [7:0] ex[$],
                       input bit slow);
      logic [7:0] got[$];
      int i;
      client.send(rq);
      client.recv(got, slow);
      `CHK("reply length", ex.size(), got.size())
      for (i = 0; i < ex.size(); i++) begin
         `CHK("reply byte", ex[i], (i < got.size()) ? got[i] : 8'hXX)
      end
   endtask
   task automatic t_wide();
      int w0;
      w0 = n_wr;
      xact({FC_WRITEN, 8'h00, 8'h02, 8'h00, 8'h02, 8'h04, 8'h41, 8'hC8,
            8'h00, 8'h00}, {FC_WRITEN, 8'h00, 8'h02, 8'h00, 8'h02}, 0);
      `CHK("write count", w0 + 2, n_wr)
      `CHK("last addr", 16'h0003, wr_addr)
      `CHK("last word", 16'h0000, wr_data)
      xact({FC_READ, 8'h00, 8'h02, 8'h00, 8'h02},
           {FC_READ, 8'h04, 8'h41, 8'hC8, 8'h00, 8'h00}, 1);
      $display("done wide write and read");
   endtask
   task automatic t_single();
      int w0;
      xact({FC_WRITE1, 8'h00, 8'h04, 8'h00, 8'h64},
           {FC_WRITE1, 8'h00, 8'h04, 8'h00, 8'h64}, 1);
      `CHK("single word", 16'h0064, wr_data)
      w0 = n_wr;
      xact({FC_WRITE1, 8'h00, 8'h04, 8'h00, 8'h65}, {8'h86, EXC_VALUE}, 0);
      `CHK("no commit", w0, n_wr)
      $display("done single write and range");
   endtask
   task automatic t_refuse();
      @(posedge core_clk);
      remote_mode <= 1'b0;
      xact({FC_WRITE1, 8'h00, 8'h00, 8'h00, 8'h01}, {8'h86, EXC_FUNC}, 0);
      @(posedge core_clk);
      remote_mode <= 1'b1;
      xact({8'h05, 8'h00, 8'h00, 8'hFF, 8'h00}, {8'h85, EXC_FUNC}, 0);
      xact({FC_INPUT, 8'h00, 8'h00, 8'h00, 8'h01}, {8'h84, EXC_ADDR}, 0);
      $display("done function refusals");
   endtask
   task automatic t_addr();
      xact({FC_READ, 8'h00, 8'hC8, 8'h00, 8'h01}, {8'h83, EXC_ADDR}, 0);
      xact({FC_READ, 8'h00, 8'h03, 8'h00, 8'h01}, {8'h83, EXC_ADDR}, 1);
      xact({FC_READ, 8'h00, 8'h01, 8'h00, 8'h02}, {8'h83, EXC_ADDR}, 0);
      xact({FC_WRITE1, 8'h00, 8'h05, 8'h00, 8'h01}, {8'h86, EXC_ADDR}, 0);
      $display("done address refusals");
   endtask
   task automatic t_rdwr();
      xact({FC_RDWR, 8'h00, 8'h04, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01,
            8'h02, 8'h00, 8'h01}, {FC_RDWR, 8'h02, 8'h00, 8'h64}, 0);
      `CHK("rdwr commit", 16'h0001, wr_data)
      $display("done combined write and read");
   endtask
   task automatic t_watchdog();
      @(posedge core_clk);
      wd_enable <= 1'b1;
      repeat (10) @(posedge core_clk);
      `CHK("no early fault", 1'b0, comm_fault)
      repeat (30) @(posedge core_clk);
      `CHK("fault", 1'b1, comm_fault)
      `CHK("fault code", FAULT_COMM, fault_code)
      // The client resends the setpoint to clear the fault
      xact({FC_WRITEN, 8'h00, 8'h02, 8'h00, 8'h02, 8'h04, 8'h41, 8'hA0,
            8'h00, 8'h00}, {FC_WRITEN, 8'h00, 8'h02, 8'h00, 8'h02}, 0);
      `CHK("fault cleared", 1'b0, comm_fault)
      `CHK("code cleared", FAULT_NONE, fault_code)
      wd_enable <= 1'b0;
      $display("done watchdog");
   endtask
   initial begin
      repeat (20) @(posedge core_clk);
      srst <= 1'b0;
      t_wide();
      t_single();
      t_refuse();
      t_addr();
      t_rdwr();
      t_watchdog();
      close_out();
   end
endmodule // tb_modbus_register_responder
